// >>> logic/tsp_pkg.sv
// Purpose: Shared constants for the trap status and priority control block
// Assumes: Classic Wishbone slave, 32-bit data, 16-bit registers in low lanes
// Notes:   Byte offsets are word aligned
package tsp_pkg;
  localparam int WB_AW = 8;
  localparam int WB_DW = 32;
  localparam int REG_W = 16;
  localparam int BE_W  = 2;

  // Register byte offsets
  localparam logic [WB_AW-1:0] ADR_CORE_CONTROL = 8'h00;
  localparam logic [WB_AW-1:0] ADR_TRAP_NEST    = 8'h04;
  localparam logic [WB_AW-1:0] ADR_CPU_STATUS   = 8'h08;

  // Core control fields
  localparam int CC_PRIO_TOP  = 3;
  localparam int CC_SAT_WRITE = 5;
  localparam logic [REG_W-1:0] CC_WMASK = 16'h18F7;
  localparam logic [REG_W-1:0] CC_RST   = 16'h0020;

  // Trap and nesting control fields
  localparam int TN_NEST_DIS  = 15;
  localparam int TN_OVA_FLAG  = 14;
  localparam int TN_OVB_FLAG  = 13;
  localparam int TN_CATA_FLAG = 12;
  localparam int TN_CATB_FLAG = 11;
  localparam int TN_OVA_EN    = 10;
  localparam int TN_OVB_EN    = 9;
  localparam int TN_CAT_EN    = 8;
  localparam int TN_SHIFT     = 7;
  localparam int TN_DIV0      = 6;
  localparam int TN_MATH      = 4;
  localparam int TN_ADDR      = 3;
  localparam int TN_STACK     = 2;
  localparam int TN_OSC       = 1;
  localparam logic [REG_W-1:0] TN_WMASK = 16'hFFDE;
  localparam logic [REG_W-1:0] TN_RST   = 16'h0000;

  // CPU status priority field
  localparam int ST_PRIO_LSB = 5;
  localparam int PRIO_LOW_W  = 3;
  localparam logic [PRIO_LOW_W-1:0] PRIO_LOW_RST = 3'h0;
  localparam logic [PRIO_LOW_W-1:0] PRIO_LOW_MAX = 3'h7;
  localparam logic [3:0]            PRIO_USER_MAX = 4'h7;
endpackage

// >>> logic/tsp_reg_if.sv
// Purpose: Register access strobes between bus slave and register bank
// Assumes: One write strobe per register, one cycle wide
// Notes:   Read values are combinational views of the bank
`timescale 1ns/1ns
`default_nettype none
interface tsp_reg_if;
  import tsp_pkg::*;
  logic              wr_core;
  logic              wr_trap;
  logic              wr_stat;
  logic [BE_W-1:0]   wr_be;
  logic [REG_W-1:0]  wr_data;
  logic [REG_W-1:0]  rd_core;
  logic [REG_W-1:0]  rd_trap;
  logic [REG_W-1:0]  rd_stat;

  modport bus  (output wr_core, wr_trap, wr_stat, wr_be, wr_data, input rd_core, rd_trap, rd_stat);
  modport bank (input wr_core, wr_trap, wr_stat, wr_be, wr_data, output rd_core, rd_trap, rd_stat);
endinterface
`default_nettype wire

// >>> logic/tsp_trap_ctrl.sv
// Purpose: Trap flags, trap enables, nesting control and priority top bit
// Assumes: Trap inputs are one-cycle pulses synchronous to clk_i
// Notes:
// Notes on behaviour
// - Priority top bit set when priority exceeds seven
// - Priority is top bit above status bits
// - Nesting disable bit blocks nested interrupts
// - Accumulator A overflow trap sets bit 14
// - Accumulator B overflow trap sets bit 13
// - Catastrophic overflow A sets bit 12
// - Catastrophic overflow B sets bit 11
// - Bit 10 enables accumulator A overflow trap
// - Bit 9 enables accumulator B overflow trap
// - Bit 8 enables catastrophic overflow traps
// - Invalid shift math trap sets bit 7
// - Divide by zero math trap sets bit 6
// - Any math trap sets bit 4
// - Address error trap sets bit 3
// - Bits 5 and 0 read zero
// - Core control top three bits read zero
// - Stack error trap sets bit 2
// - Oscillator failure trap sets bit 1
// - Nesting disabled makes low priority read-only
// - Top priority bit blocks all user interrupts
//
// Our own choices: the register offsets and the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
module tsp_trap_ctrl (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [tsp_pkg::WB_AW-1:0]   wb_adr_i,
  input  wire logic [3:0]                  wb_sel_i,
  input  wire logic [tsp_pkg::WB_DW-1:0]   wb_dat_i,
  output logic      [tsp_pkg::WB_DW-1:0]   wb_dat_o,
  output logic                             wb_ack_o,
  input  wire logic                        acc_a_ovf_i,
  input  wire logic                        acc_b_ovf_i,
  input  wire logic                        acc_a_cat_i,
  input  wire logic                        acc_b_cat_i,
  input  wire logic                        bad_shift_i,
  input  wire logic                        divide_zero_i,
  input  wire logic                        address_err_i,
  input  wire logic                        stack_err_i,
  input  wire logic                        osc_fail_i,
  output logic      [3:0]                  cpu_priority_o,
  output logic                             user_irq_block_o,
  output logic                             nesting_allowed_o,
  output logic                             trap_taken_o,
  output logic                             math_trap_o
);
  import tsp_pkg::*;

  tsp_reg_if regs ();

  logic [REG_W-1:0]      core_control_r;
  logic [REG_W-1:0]      core_control_nxt;
  logic [REG_W-1:0]      trap_nest_r;
  logic [REG_W-1:0]      trap_nest_nxt;
  logic [REG_W-1:0]      trap_set;
  logic [PRIO_LOW_W-1:0] cpu_priority_low_bits_r;
  logic [PRIO_LOW_W-1:0] cpu_priority_low_bits_nxt;
  logic                  trap_taken_r;
  logic                  math_trap_r;
  wire  [REG_W-1:0]      core_merge;
  wire                   acc_a_trap;
  wire                   acc_b_trap;
  wire                   cat_a_trap;
  wire                   cat_b_trap;
  wire                   math_any;
  wire                   any_trap;
  wire                   nesting_disable;
  wire                   cpu_priority_top_bit;
  wire                   prio_top_clear;

  tsp_wb_slave u_bus (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i  (wb_we_i),
    .wb_adr_i (wb_adr_i),
    .wb_sel_i (wb_sel_i),
    .wb_dat_i (wb_dat_i),
    .wb_dat_o (wb_dat_o),
    .wb_ack_o (wb_ack_o),
    .regs     (regs.bus)
  );

  // Trap qualification by enables
  assign acc_a_trap = acc_a_ovf_i & trap_nest_r[TN_OVA_EN];
  assign acc_b_trap = acc_b_ovf_i & trap_nest_r[TN_OVB_EN];
  assign cat_a_trap = acc_a_cat_i & trap_nest_r[TN_CAT_EN];
  assign cat_b_trap = acc_b_cat_i & trap_nest_r[TN_CAT_EN];
  assign math_any   = acc_a_trap | acc_b_trap | cat_a_trap | cat_b_trap | bad_shift_i | divide_zero_i;
  assign any_trap   = math_any | address_err_i | stack_err_i | osc_fail_i;

  always_comb begin
    trap_set               = '0;
    trap_set[TN_OVA_FLAG]  = acc_a_trap;
    trap_set[TN_OVB_FLAG]  = acc_b_trap;
    trap_set[TN_CATA_FLAG] = cat_a_trap;
    trap_set[TN_CATB_FLAG] = cat_b_trap;
    trap_set[TN_SHIFT]     = bad_shift_i;
    trap_set[TN_DIV0]      = divide_zero_i;
    trap_set[TN_MATH]      = math_any;
    trap_set[TN_ADDR]      = address_err_i;
    trap_set[TN_STACK]     = stack_err_i;
    trap_set[TN_OSC]       = osc_fail_i;
  end

  // Per-bit trap register update, hardware set wins over software clear
  for (genvar g = 0; g < REG_W; g++) begin : g_trap_bit
    if (TN_WMASK[g]) begin : g_impl
      assign trap_nest_nxt[g] = trap_set[g] |
        ((regs.wr_trap & regs.wr_be[g/8]) ? regs.wr_data[g] : trap_nest_r[g]);
    end else begin : g_none
      assign trap_nest_nxt[g] = 1'b0;
    end
  end

  // Core control merge and priority top bit
  for (genvar c = 0; c < REG_W; c++) begin : g_core_bit
    assign core_merge[c] = (regs.wr_core & regs.wr_be[c/8] & CC_WMASK[c]) ?
                           regs.wr_data[c] : core_control_r[c];
  end
  assign prio_top_clear = regs.wr_core & regs.wr_be[0] & ~regs.wr_data[CC_PRIO_TOP];

  always_comb begin
    core_control_nxt              = core_merge & CC_WMASK;
    core_control_nxt[CC_PRIO_TOP] = any_trap |
      (core_control_r[CC_PRIO_TOP] & ~prio_top_clear);
  end

  assign nesting_disable = trap_nest_r[TN_NEST_DIS];
  assign cpu_priority_low_bits_nxt = (regs.wr_stat & regs.wr_be[0] & ~nesting_disable) ?
    regs.wr_data[ST_PRIO_LSB +: PRIO_LOW_W] : cpu_priority_low_bits_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_control_r          <= CC_RST;
      trap_nest_r             <= TN_RST;
      cpu_priority_low_bits_r <= PRIO_LOW_RST;
      trap_taken_r            <= 1'b0;
      math_trap_r             <= 1'b0;
    end else begin
      core_control_r          <= core_control_nxt;
      trap_nest_r             <= trap_nest_nxt;
      cpu_priority_low_bits_r <= cpu_priority_low_bits_nxt;
      trap_taken_r            <= any_trap;
      math_trap_r             <= math_any;
    end
  end

  assign cpu_priority_top_bit = core_control_r[CC_PRIO_TOP];

  // Register read views
  assign regs.rd_core = core_control_r & (CC_WMASK | (REG_W'(1) << CC_PRIO_TOP));
  assign regs.rd_trap = trap_nest_r & TN_WMASK;
  assign regs.rd_stat = {{(REG_W-ST_PRIO_LSB-PRIO_LOW_W){1'b0}}, cpu_priority_low_bits_r,
                         {ST_PRIO_LSB{1'b0}}};

  // Priority and interrupt gating outputs
  assign cpu_priority_o    = {cpu_priority_top_bit, cpu_priority_low_bits_r};
  assign user_irq_block_o  = cpu_priority_top_bit |
                             (cpu_priority_low_bits_r == PRIO_LOW_MAX);
  assign nesting_allowed_o = ~nesting_disable;
  assign trap_taken_o      = trap_taken_r;
  assign math_trap_o       = math_trap_r;

  // Checks
  property p_prio_top;
    @(posedge clk_i) disable iff (rst_i)
    (cpu_priority_o > PRIO_USER_MAX) == regs.rd_core[CC_PRIO_TOP];
  endproperty
  a_prio_top: assert property (p_prio_top) else $error("priority top bit mismatch");

  property p_ova_set;
    @(posedge clk_i) disable iff (rst_i)
    acc_a_ovf_i && trap_nest_r[TN_OVA_EN] |=> regs.rd_trap[TN_OVA_FLAG] && regs.rd_trap[TN_MATH]
      && cpu_priority_top_bit && math_trap_o;
  endproperty
  a_ova_set: assert property (p_ova_set) else $error("acc A overflow trap not flagged");

  property p_ova_off;
    @(posedge clk_i) disable iff (rst_i)
    !trap_nest_r[TN_OVA_FLAG] && acc_a_ovf_i && !trap_nest_r[TN_OVA_EN] && !regs.wr_trap
      |=> !trap_nest_r[TN_OVA_FLAG];
  endproperty
  a_ova_off: assert property (p_ova_off) else $error("disabled acc A trap flagged");

  property p_cat_b;
    @(posedge clk_i) disable iff (rst_i)
    acc_b_cat_i && trap_nest_r[TN_CAT_EN] |=> trap_nest_r[TN_CATB_FLAG] && trap_nest_r[TN_MATH];
  endproperty
  a_cat_b: assert property (p_cat_b) else $error("catastrophic B trap not flagged");

  property p_div0;
    @(posedge clk_i) disable iff (rst_i)
    divide_zero_i |=> trap_nest_r[TN_DIV0] && trap_nest_r[TN_MATH] && trap_taken_o;
  endproperty
  a_div0: assert property (p_div0) else $error("divide by zero not flagged");

  property p_addr;
    @(posedge clk_i) disable iff (rst_i)
    address_err_i |=> trap_nest_r[TN_ADDR] && trap_taken_o;
  endproperty
  a_addr: assert property (p_addr) else $error("address error not flagged");

  property p_zero_bits;
    @(posedge clk_i) disable iff (rst_i)
    trap_nest_r[5] == 1'b0 && trap_nest_r[0] == 1'b0 && core_control_r[15:13] == 3'h0
      && wb_dat_o[31:16] == 16'h0000;
  endproperty
  a_zero_bits: assert property (p_zero_bits) else $error("unimplemented bit reads one");

  property p_prio_locked;
    @(posedge clk_i) disable iff (rst_i)
    nesting_disable && regs.wr_stat |=> $stable(cpu_priority_o[2:0]);
  endproperty
  a_prio_locked: assert property (p_prio_locked) else $error("priority written while locked");

  property p_block;
    @(posedge clk_i) disable iff (rst_i)
    cpu_priority_o[3] |-> user_irq_block_o;
  endproperty
  a_block: assert property (p_block) else $error("user interrupts not blocked");

  property p_sticky;
    @(posedge clk_i) disable iff (rst_i)
    trap_nest_r[TN_STACK] && !regs.wr_trap |=> trap_nest_r[TN_STACK];
  endproperty
  a_sticky: assert property (p_sticky) else $error("stack flag cleared by itself");

  property p_prio_rise;
    @(posedge clk_i) disable iff (rst_i)
    any_trap |=> cpu_priority_top_bit && (cpu_priority_o > PRIO_USER_MAX);
  endproperty
  a_prio_rise: assert property (p_prio_rise) else $error("trap did not raise priority top bit");

  property p_top_clear;
    @(posedge clk_i) disable iff (rst_i)
    cpu_priority_top_bit && !any_trap && prio_top_clear |=> !cpu_priority_top_bit;
  endproperty
  a_top_clear: assert property (p_top_clear) else $error("priority top bit not cleared");

  property p_prio_write;
    @(posedge clk_i) disable iff (rst_i)
    !nesting_disable && regs.wr_stat && regs.wr_be[0]
      |=> cpu_priority_o[2:0] == $past(regs.wr_data[ST_PRIO_LSB +: PRIO_LOW_W]);
  endproperty
  a_prio_write: assert property (p_prio_write) else $error("priority low bits not written");

  property p_ovb_set;
    @(posedge clk_i) disable iff (rst_i)
    acc_b_ovf_i && trap_nest_r[TN_OVB_EN] |=> trap_nest_r[TN_OVB_FLAG] && trap_nest_r[TN_MATH];
  endproperty
  a_ovb_set: assert property (p_ovb_set) else $error("acc B overflow trap not flagged");

  property p_cat_a;
    @(posedge clk_i) disable iff (rst_i)
    acc_a_cat_i && trap_nest_r[TN_CAT_EN] |=> trap_nest_r[TN_CATA_FLAG] && trap_nest_r[TN_MATH];
  endproperty
  a_cat_a: assert property (p_cat_a) else $error("catastrophic A trap not flagged");

  property p_ovb_off;
    @(posedge clk_i) disable iff (rst_i)
    !trap_nest_r[TN_OVB_FLAG] && acc_b_ovf_i && !trap_nest_r[TN_OVB_EN] && !regs.wr_trap
      |=> !trap_nest_r[TN_OVB_FLAG];
  endproperty
  a_ovb_off: assert property (p_ovb_off) else $error("disabled acc B trap flagged");

  property p_cat_off;
    @(posedge clk_i) disable iff (rst_i)
    !trap_nest_r[TN_CATB_FLAG] && acc_b_cat_i && !trap_nest_r[TN_CAT_EN] && !regs.wr_trap
      |=> !trap_nest_r[TN_CATB_FLAG];
  endproperty
  a_cat_off: assert property (p_cat_off) else $error("disabled catastrophic trap flagged");

  property p_shift;
    @(posedge clk_i) disable iff (rst_i)
    bad_shift_i |=> trap_nest_r[TN_SHIFT] && trap_nest_r[TN_MATH] && math_trap_o;
  endproperty
  a_shift: assert property (p_shift) else $error("bad shift not flagged");

  property p_stack;
    @(posedge clk_i) disable iff (rst_i)
    stack_err_i |=> trap_nest_r[TN_STACK] && trap_taken_o;
  endproperty
  a_stack: assert property (p_stack) else $error("stack error not flagged");

  property p_osc;
    @(posedge clk_i) disable iff (rst_i)
    osc_fail_i |=> trap_nest_r[TN_OSC] && trap_taken_o;
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator failure not flagged");

  property p_math_only;
    @(posedge clk_i) disable iff (rst_i)
    math_trap_o |-> trap_nest_r[TN_MATH];
  endproperty
  a_math_only: assert property (p_math_only) else $error("math pulse without math flag");

  property p_reset_vals;
    @(posedge clk_i)
    rst_i ##1 !rst_i |-> core_control_r == CC_RST && trap_nest_r == TN_RST
      && cpu_priority_low_bits_r == PRIO_LOW_RST;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");
endmodule // tsp_trap_ctrl
`default_nettype wire

// >>> logic/tsp_wb_slave.sv
// Purpose: Classic Wishbone slave for the trap control registers
// Assumes: Single-cycle requests, cyc and stb held until ack
// Notes:   Ack one cycle after request, unmapped reads return zero
`timescale 1ns/1ns
`default_nettype none
module tsp_wb_slave (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [tsp_pkg::WB_AW-1:0]   wb_adr_i,
  input  wire logic [3:0]                  wb_sel_i,
  input  wire logic [tsp_pkg::WB_DW-1:0]   wb_dat_i,
  output logic      [tsp_pkg::WB_DW-1:0]   wb_dat_o,
  output logic                             wb_ack_o,
  tsp_reg_if.bus                           regs
);
  import tsp_pkg::*;

  logic              ack_r;
  logic [REG_W-1:0]  dat_r;
  logic [REG_W-1:0]  dat_nxt;
  wire               take;
  wire  [WB_AW-1:0]  word_adr;
  wire               hit_core;
  wire               hit_trap;
  wire               hit_stat;

  // Aligned word decode
  assign take     = wb_cyc_i & wb_stb_i & ~ack_r;
  assign word_adr = {wb_adr_i[WB_AW-1:2], 2'h0};
  assign hit_core = (word_adr == ADR_CORE_CONTROL);
  assign hit_trap = (word_adr == ADR_TRAP_NEST);
  assign hit_stat = (word_adr == ADR_CPU_STATUS);

  assign regs.wr_core = take & wb_we_i & hit_core;
  assign regs.wr_trap = take & wb_we_i & hit_trap;
  assign regs.wr_stat = take & wb_we_i & hit_stat;
  assign regs.wr_be   = wb_sel_i[BE_W-1:0];
  assign regs.wr_data = wb_dat_i[REG_W-1:0];

  assign dat_nxt = hit_core ? regs.rd_core :
                   hit_trap ? regs.rd_trap :
                   hit_stat ? regs.rd_stat : '0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= '0;
    end else begin
      ack_r <= take;
      if (take) begin
        dat_r <= dat_nxt;
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = {{(WB_DW-REG_W){1'b0}}, dat_r};
endmodule // tsp_wb_slave
`default_nettype wire

// >>> sim/tb.sv
// Purpose: Self-checking bench for the trap status and priority block
// Assumes: Classic Wishbone master, one request at a time
// Notes:   Cause order a_ovf, b_ovf, a_cat, b_cat, shift, div0, addr, stack, osc
`timescale 1ns/1ns
`default_nettype none
module tb;
  import tsp_pkg::*;
  logic             clk_i      = 1'b0;
  logic             rst_i      = 1'b1;
  logic             wb_cyc_i   = 1'b0;
  logic             wb_stb_i   = 1'b0;
  logic             wb_we_i    = 1'b0;
  logic [WB_AW-1:0] wb_adr_i   = 8'h00;
  logic [3:0]       wb_sel_i   = 4'h0;
  logic [WB_DW-1:0] wb_dat_i   = 32'h0;
  logic [WB_DW-1:0] wb_dat_o;
  logic             wb_ack_o;
  logic [8:0]       req_r      = 9'h000;
  logic [3:0]       sel_v      = 4'hF;
  logic [8:0]       cause;
  logic [3:0]       cpu_priority_o;
  logic             user_irq_block_o;
  logic             nesting_allowed_o;
  logic             trap_taken_o;
  logic             math_trap_o;
  logic [REG_W-1:0] e;
  logic [WB_DW-1:0] q;
  int               err_total  = 0;
  int               num_checks = 0;
  int               n_taken    = 0;
  int               n_math     = 0;
  int               fbit [9]   = '{14, 13, 12, 11, 7, 6, 3, 2, 1};

  always #5 clk_i = ~clk_i;

  tsp_trap_src src (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_r), .cause_o(cause));

  tsp_trap_ctrl dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .acc_a_ovf_i(cause[0]), .acc_b_ovf_i(cause[1]), .acc_a_cat_i(cause[2]),
    .acc_b_cat_i(cause[3]), .bad_shift_i(cause[4]), .divide_zero_i(cause[5]),
    .address_err_i(cause[6]), .stack_err_i(cause[7]), .osc_fail_i(cause[8]),
    .cpu_priority_o(cpu_priority_o), .user_irq_block_o(user_irq_block_o),
    .nesting_allowed_o(nesting_allowed_o), .trap_taken_o(trap_taken_o), .math_trap_o(math_trap_o)
  );

  // Pulse counters
  always @(posedge clk_i) begin
    if (trap_taken_o === 1'b1) n_taken++;
    if (math_trap_o === 1'b1) n_math++;
  end

  task automatic results();
    if (err_total == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [WB_DW-1:0] ex, input logic [WB_DW-1:0] g);
    num_checks++;
    if (g !== ex) begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", nm, ex, g);
    end
  endtask

  // One classic cycle, entered just after a rising edge
  task automatic wb(input logic we, input logic [WB_AW-1:0] a, input logic [REG_W-1:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_sel_i <= sel_v;
    wb_dat_i <= {16'h0000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      err_total++;
      results();
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [WB_AW-1:0] a, input logic [REG_W-1:0] d);
    wb(1'b1, a, d);
  endtask

  task automatic rd(input string nm, input logic [WB_AW-1:0] a, input logic [REG_W-1:0] ex);
    wb(1'b0, a, 16'h0000);
    chk(nm, {16'h0000, ex}, q);
  endtask

  task automatic pulse(input int i);
    req_r <= 9'h001 << i;
    @(posedge clk_i);
    req_r <= 9'h000;
    repeat (3) @(posedge clk_i);
  endtask

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd("core", ADR_CORE_CONTROL, 16'h0020);
    rd("trap", ADR_TRAP_NEST, 16'h0000);
    rd("stat", ADR_CPU_STATUS, 16'h0000);
    chk("nest", 32'h1, nesting_allowed_o);
    wr(ADR_CORE_CONTROL, 16'hFFFF);
    rd("core", ADR_CORE_CONTROL, 16'h18F7);
    wr(ADR_CORE_CONTROL, 16'h0020);
    wr(ADR_TRAP_NEST, 16'hFFFF);
    rd("trap", ADR_TRAP_NEST, 16'hFFDE);
    chk("nest", 32'h0, nesting_allowed_o);
    wr(ADR_CPU_STATUS, 16'h00E0);
    rd("stat", ADR_CPU_STATUS, 16'h0000);
    wr(ADR_TRAP_NEST, 16'h0000);
    rd("trap", ADR_TRAP_NEST, 16'h0000);
    // Enables off: overflow causes dropped
    for (int i = 0; i < 4; i++) pulse(i);
    rd("trap", ADR_TRAP_NEST, 16'h0000);
    chk("taken", 32'd0, n_taken);
    chk("prio", 32'h0, cpu_priority_o);
    wr(ADR_TRAP_NEST, 16'h0700);
    for (int i = 0; i < 9; i++) begin
      pulse(i);
      e = 16'h0700 | (16'h0001 << fbit[i]) | ((i < 6) ? 16'h0010 : 16'h0000);
      rd("trap", ADR_TRAP_NEST, e);
      rd("core", ADR_CORE_CONTROL, 16'h0028);
      chk("prio", 32'h8, cpu_priority_o);
      chk("block", 32'h1, user_irq_block_o);
      rd("trap", ADR_TRAP_NEST, e);
      wr(ADR_TRAP_NEST, 16'h0700);
      wr(ADR_CORE_CONTROL, 16'h0020);
    end
    chk("taken", 32'd9, n_taken);
    chk("math", 32'd6, n_math);
    chk("block", 32'h0, user_irq_block_o);
    wr(ADR_CPU_STATUS, 16'h00E0);
    rd("stat", ADR_CPU_STATUS, 16'h00E0);
    chk("prio", 32'h7, cpu_priority_o);
    chk("block", 32'h1, user_irq_block_o);
    wr(ADR_CPU_STATUS, 16'h0040);
    chk("prio", 32'h2, cpu_priority_o);
    chk("block", 32'h0, user_irq_block_o);
    wr(8'h0C, 16'hFFFF);
    rd("unmapped", 8'h0C, 16'h0000);
    sel_v = 4'h1;
    wr(ADR_TRAP_NEST, 16'hFFFF);
    rd("trap", ADR_TRAP_NEST, 16'h07DE);
    sel_v = 4'h2;
    wr(ADR_TRAP_NEST, 16'h0000);
    rd("trap", ADR_TRAP_NEST, 16'h00DE);
    sel_v = 4'hF;
    wr(ADR_CORE_CONTROL, 16'h0000);
    rd("core", ADR_CORE_CONTROL, 16'h0000);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd("core", ADR_CORE_CONTROL, 16'h0020);
    rd("stat", ADR_CPU_STATUS, 16'h0000);
    rd("trap", ADR_TRAP_NEST, 16'h0000);
    results();
  end
endmodule // tb
`default_nettype wire

// >>> sim/tsp_trap_src.sv
// Purpose: Far-side model of the core trap cause sources
// Assumes: Bench raises a request bit for one cycle per event
// Notes:   Each request becomes a one-cycle registered cause pulse
`timescale 1ns/1ns
`default_nettype none
module tsp_trap_src (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [8:0] req_i,
  output logic      [8:0] cause_o
);
  // Causes drop back to idle after one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cause_o <= 9'h000;
    end else begin
      cause_o <= req_i;
    end
  end
endmodule // tsp_trap_src
`default_nettype wire
